/* File: burst_cmd_bank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "burst_cmd_defines.svh"

// Summary of operation
// - Deselect or no-operation during a read burst lets it finish, then the bank is row active.
// - Burst terminate during a read burst ends it and leaves the row open and active.
// - A read during a read burst drops the old burst and starts a new one at the new column.
// - A precharge of this bank or of all banks during a read burst stops it and closes the row.
// - Deselect or no-operation during a write burst lets it finish, then write recovery follows.
// - Burst terminate during a write burst ends it and leaves the bank row active.
// - A read during a write burst drops the write and starts a read burst at the new column.
// - A write during a write burst drops the old burst and restarts at the new column.
// - A precharge of this bank or of all banks during a write burst stops it and closes the row.
// - A read burst with autoclose runs to its end and the row then closes by itself.
// - In write recovery after a write without autoclose, quiet commands wait out the recovery time, then the bank is row active.

module burst_cmd_bank #(
    parameter int unsigned BURST_LEN  = `BURST_LEN_DEFAULT,
    parameter int unsigned FIFO_DEPTH = `FIFO_DEPTH_DEFAULT,
    parameter logic        BANK_ID    = 1'b0
) (
    input  wire logic                      sys_clk,        // 40 MHz clock
    input  wire logic                      srst,           // Sync reset
    input  wire burst_cmd_pkg::pins_t      pins,           // Command pins
    input  wire logic                      array_ready,    // Array takes req
    output logic                           array_valid,    // Request present
    output burst_cmd_pkg::array_req_t      array_req,      // Array request
    output burst_cmd_pkg::bank_state_t     bank_state,     // Bank state
    output logic [`ADDR_W-1:0]             open_row,       // Row held open
    output logic                           autoclose_done  // Read autoclose pulse
);

    // ************************************************************
    // Cycle counts derived from the timing figures
    // ************************************************************
    localparam int TWR_RAW = (`WRITE_RECOVERY_NS + `CLK_PERIOD_NS - 1)
                             / `CLK_PERIOD_NS;
    localparam int TRP_RAW = (`ROW_CLOSE_NS + `CLK_PERIOD_NS - 1)
                             / `CLK_PERIOD_NS;
    localparam int TWR_CYC = (TWR_RAW < 1) ? 1 : TWR_RAW;
    localparam int TRP_CYC = (TRP_RAW < 1) ? 1 : TRP_RAW;

    localparam int REQ_W = $bits(burst_cmd_pkg::array_req_t);

    burst_cmd_pkg::bank_regs_t s;
    burst_cmd_pkg::bank_regs_t n;
    burst_cmd_pkg::cmd_t       cmd;
    burst_cmd_pkg::array_req_t req;
    logic                      beat;
    logic                      fifo_ready;
    logic                      hit;
    logic                      col_cmd;
    logic                      close_hit;
    logic                      quiet;
    logic [`COL_W-1:0]         column;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic burst_cmd_pkg::cmd_t decode(
        input burst_cmd_pkg::pins_t p
    );
        logic ac;
        ac = p.addr[`AUTOCLOSE_BIT];
        if (p.cs_n) begin
            return burst_cmd_pkg::device_unselected;
        end
        unique case ({p.ras_n, p.cas_n, p.we_n})
            3'h7: return burst_cmd_pkg::no_operation;
            3'h6: return burst_cmd_pkg::burst_terminate;
            3'h5: return ac ? burst_cmd_pkg::read_with_autoclose
                            : burst_cmd_pkg::read_cmd;
            3'h4: return ac ? burst_cmd_pkg::store_with_autoclose
                            : burst_cmd_pkg::column_store_cmd;
            3'h3: return burst_cmd_pkg::row_open;
            3'h2: return ac ? burst_cmd_pkg::bank_close_all
                            : burst_cmd_pkg::bank_close;
            3'h1: return burst_cmd_pkg::refresh_cmd;
            3'h0: return burst_cmd_pkg::mode_register_load;
        endcase
    endfunction

    function automatic burst_cmd_pkg::bank_regs_t start_burst(
        input burst_cmd_pkg::bank_regs_t r,
        input burst_cmd_pkg::cmd_t       c,
        input logic [`COL_W-1:0]         col
    );
        burst_cmd_pkg::bank_regs_t o;
        o             = r;
        o.col         = col;
        o.remain      = `REMAIN_W'(BURST_LEN);
        o.close_after = 1'b0;
        unique case (c)
            burst_cmd_pkg::read_cmd:
                o.st = burst_cmd_pkg::st_reading;
            burst_cmd_pkg::read_with_autoclose:
                o.st = burst_cmd_pkg::st_reading_autoclose;
            burst_cmd_pkg::column_store_cmd:
                o.st = burst_cmd_pkg::st_storing;
            default:
                o.st = burst_cmd_pkg::st_storing_autoclose;
        endcase
        return o;
    endfunction

    function automatic burst_cmd_pkg::bank_regs_t begin_close(
        input burst_cmd_pkg::bank_regs_t r
    );
        burst_cmd_pkg::bank_regs_t o;
        o       = r;
        o.st    = burst_cmd_pkg::st_row_closing;
        o.timer = `TIMER_W'(TRP_CYC);
        return o;
    endfunction

    // ************************************************************
    // Command qualification on the synchronised pins
    // ************************************************************
    assign cmd       = decode(s.pin_s2);
    assign hit       = s.pin_s2.bank_sel == BANK_ID;
    assign column    = s.pin_s2.addr[`COL_W-1:0];
    assign col_cmd   = hit && (cmd == burst_cmd_pkg::read_cmd ||
                       cmd == burst_cmd_pkg::read_with_autoclose ||
                       cmd == burst_cmd_pkg::column_store_cmd ||
                       cmd == burst_cmd_pkg::store_with_autoclose);
    assign close_hit = cmd == burst_cmd_pkg::bank_close_all ||
                       (hit && cmd == burst_cmd_pkg::bank_close);
    assign quiet     = cmd == burst_cmd_pkg::device_unselected ||
                       cmd == burst_cmd_pkg::no_operation;

    // ************************************************************
    // Bank state machine
    // ************************************************************
    always_comb begin
        n                = s;
        beat             = 1'b0;
        n.pin_s1         = pins;
        n.pin_s2         = s.pin_s1;
        n.autoclose_done = 1'b0;
        unique case (s.st)
            burst_cmd_pkg::st_idle: begin
                if (hit && cmd == burst_cmd_pkg::row_open) begin
                    n.st  = burst_cmd_pkg::st_row_active;
                    n.row = s.pin_s2.addr;
                end
            end
            burst_cmd_pkg::st_row_active: begin
                if (col_cmd) begin
                    n = start_burst(n, cmd, column);
                end else if (close_hit) begin
                    n = begin_close(n);
                end
            end
            burst_cmd_pkg::st_reading, burst_cmd_pkg::st_storing: begin
                if (cmd == burst_cmd_pkg::burst_terminate) begin
                    n.st = burst_cmd_pkg::st_row_active;
                end else if (col_cmd) begin
                    n = start_burst(n, cmd, column);
                end else if (close_hit) begin
                    n = begin_close(n);
                end else if (fifo_ready) begin
                    beat     = 1'b1;
                    n.col    = s.col + `COL_W'(1);
                    n.remain = s.remain - `REMAIN_W'(1);
                    if (s.remain == `REMAIN_W'(1)) begin
                        if (s.st == burst_cmd_pkg::st_reading) begin
                            n.st = burst_cmd_pkg::st_row_active;
                        end else begin
                            n.st    = burst_cmd_pkg::st_write_recovery;
                            n.timer = `TIMER_W'(TWR_CYC);
                        end
                    end
                end
            end
            burst_cmd_pkg::st_reading_autoclose,
            burst_cmd_pkg::st_storing_autoclose: begin
                if (fifo_ready) begin
                    beat     = 1'b1;
                    n.col    = s.col + `COL_W'(1);
                    n.remain = s.remain - `REMAIN_W'(1);
                    if (s.remain == `REMAIN_W'(1)) begin
                        if (s.st == burst_cmd_pkg::st_reading_autoclose) begin
                            n                = begin_close(n);
                            n.autoclose_done = 1'b1;
                        end else begin
                            n.st          = burst_cmd_pkg::st_write_recovery;
                            n.timer       = `TIMER_W'(TWR_CYC);
                            n.close_after = 1'b1;
                        end
                    end
                end
            end
            burst_cmd_pkg::st_write_recovery: begin
                if (col_cmd && !s.close_after) begin
                    n = start_burst(n, cmd, column);
                end else if (s.timer == `TIMER_W'(1)) begin
                    if (s.close_after) begin
                        n = begin_close(n);
                    end else begin
                        n.st = burst_cmd_pkg::st_row_active;
                    end
                end else begin
                    n.timer = s.timer - `TIMER_W'(1);
                end
            end
            burst_cmd_pkg::st_row_closing: begin
                if (s.timer == `TIMER_W'(1)) begin
                    n.st = burst_cmd_pkg::st_idle;
                end else begin
                    n.timer = s.timer - `TIMER_W'(1);
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // ************************************************************
    // Request queue towards the array
    // ************************************************************
    always_comb begin
        req.is_store = s.st == burst_cmd_pkg::st_storing ||
                       s.st == burst_cmd_pkg::st_storing_autoclose;
        req.row      = s.row;
        req.col      = s.col;
        req.data     = s.pin_s2.dq;
    end

    burst_fifo #(
        .WIDTH (REQ_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .in_valid  (beat),
        .in_ready  (fifo_ready),
        .in_data   (req),
        .out_valid (array_valid),
        .out_ready (array_ready),
        .out_data  (array_req)
    );

    assign bank_state     = s.st;
    assign open_row       = s.row;
    assign autoclose_done = s.autoclose_done;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    property p_read_finish;
        (s.st == burst_cmd_pkg::st_reading) && quiet && fifo_ready &&
        (s.remain == `REMAIN_W'(1))
        |=> (s.st == burst_cmd_pkg::st_row_active) && (s.row == $past(s.row));
    endproperty
    a_read_finish: assert property (p_read_finish)
        else $error("read burst did not end in row active");

    property p_read_stop;
        (s.st == burst_cmd_pkg::st_reading) &&
        (cmd == burst_cmd_pkg::burst_terminate)
        |=> (s.st == burst_cmd_pkg::st_row_active) && !beat;
    endproperty
    a_read_stop: assert property (p_read_stop)
        else $error("burst terminate did not stop read");

    property p_read_restart;
        (s.st == burst_cmd_pkg::st_reading) && col_cmd &&
        (cmd == burst_cmd_pkg::read_cmd)
        |=> (s.st == burst_cmd_pkg::st_reading) &&
            (s.col == $past(column)) &&
            (s.remain == `REMAIN_W'(BURST_LEN));
    endproperty
    a_read_restart: assert property (p_read_restart)
        else $error("read did not restart at new column");

    property p_read_close;
        (s.st == burst_cmd_pkg::st_reading) && close_hit
        |=> (s.st == burst_cmd_pkg::st_row_closing) &&
            (s.timer == `TIMER_W'(TRP_CYC));
    endproperty
    a_read_close: assert property (p_read_close)
        else $error("precharge did not close row during read");

    property p_write_finish;
        (s.st == burst_cmd_pkg::st_storing) && quiet && fifo_ready &&
        (s.remain == `REMAIN_W'(1))
        |=> (s.st == burst_cmd_pkg::st_write_recovery) &&
            (s.timer == `TIMER_W'(TWR_CYC));
    endproperty
    a_write_finish: assert property (p_write_finish)
        else $error("write burst did not enter recovery");

    property p_write_stop;
        (s.st == burst_cmd_pkg::st_storing) &&
        (cmd == burst_cmd_pkg::burst_terminate)
        |=> s.st == burst_cmd_pkg::st_row_active;
    endproperty
    a_write_stop: assert property (p_write_stop)
        else $error("burst terminate did not stop write");

    property p_write_to_read;
        (s.st == burst_cmd_pkg::st_storing) && col_cmd &&
        (cmd == burst_cmd_pkg::read_cmd)
        |=> (s.st == burst_cmd_pkg::st_reading) && (s.col == $past(column));
    endproperty
    a_write_to_read: assert property (p_write_to_read)
        else $error("read did not interrupt write");

    property p_write_restart;
        (s.st == burst_cmd_pkg::st_storing) && col_cmd &&
        (cmd == burst_cmd_pkg::column_store_cmd)
        |=> (s.st == burst_cmd_pkg::st_storing) &&
            (s.col == $past(column)) &&
            (s.remain == `REMAIN_W'(BURST_LEN));
    endproperty
    a_write_restart: assert property (p_write_restart)
        else $error("write did not restart at new column");

    property p_write_close;
        (s.st == burst_cmd_pkg::st_storing) && close_hit
        |=> (s.st == burst_cmd_pkg::st_row_closing) &&
            (s.timer == `TIMER_W'(TRP_CYC));
    endproperty
    a_write_close: assert property (p_write_close)
        else $error("precharge did not close row during write");

    property p_autoclose;
        (s.st == burst_cmd_pkg::st_reading_autoclose) && fifo_ready &&
        (s.remain == `REMAIN_W'(1))
        |=> (s.st == burst_cmd_pkg::st_row_closing) && autoclose_done
            ##1 !autoclose_done;
    endproperty
    a_autoclose: assert property (p_autoclose)
        else $error("autoclose read did not close the row");

    property p_recovery;
        $rose(s.st == burst_cmd_pkg::st_write_recovery) && !s.close_after
        && quiet
        |-> (s.st == burst_cmd_pkg::st_write_recovery) ##TWR_CYC
            (s.st == burst_cmd_pkg::st_row_active || col_cmd ||
             $past(col_cmd) || !$past(quiet));
    endproperty
    a_recovery: assert property (p_recovery)
        else $error("write recovery did not end in row active");

endmodule

`default_nettype wire

/* File: burst_cmd_defines.svh */
`ifndef BURST_CMD_DEFINES_SVH
`define BURST_CMD_DEFINES_SVH

// ****************************************************************
// Widths of the command pins, of the array requests and of the bank counters
// ****************************************************************
`define ADDR_W              11
`define COL_W               8
`define DATA_W              16
`define AUTOCLOSE_BIT       10
`define REMAIN_W            9
`define TIMER_W             8

// ****************************************************************
// Timing, in nanoseconds, and structural defaults
// ****************************************************************
`define CLK_PERIOD_NS       25
`define WRITE_RECOVERY_NS   20
`define ROW_CLOSE_NS        20
`define BURST_LEN_DEFAULT   4
`define FIFO_DEPTH_DEFAULT  8

`endif

/* File: burst_cmd_pkg.sv */
`include "burst_cmd_defines.svh"

package burst_cmd_pkg;

    // ************************************************************
    // Decoded commands and bank states
    // ************************************************************
    typedef enum logic [3:0] {
        device_unselected,
        no_operation,
        burst_terminate,
        read_cmd,
        read_with_autoclose,
        column_store_cmd,
        store_with_autoclose,
        bank_close,
        bank_close_all,
        row_open,
        refresh_cmd,
        mode_register_load
    } cmd_t;

    typedef enum logic [2:0] {
        st_idle,
        st_row_active,
        st_reading,
        st_reading_autoclose,
        st_storing,
        st_storing_autoclose,
        st_write_recovery,
        st_row_closing
    } bank_state_t;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic                 cs_n;
        logic                 ras_n;
        logic                 cas_n;
        logic                 we_n;
        logic                 bank_sel;
        logic [`ADDR_W-1:0]   addr;
        logic [`DATA_W-1:0]   dq;
    } pins_t;

    typedef struct packed {
        logic                 is_store;
        logic [`ADDR_W-1:0]   row;
        logic [`COL_W-1:0]    col;
        logic [`DATA_W-1:0]   data;
    } array_req_t;

    typedef struct packed {
        pins_t                pin_s1;
        pins_t                pin_s2;
        bank_state_t          st;
        logic [`ADDR_W-1:0]   row;
        logic [`COL_W-1:0]    col;
        logic [`REMAIN_W-1:0] remain;
        logic [`TIMER_W-1:0]  timer;
        logic                 close_after;
        logic                 autoclose_done;
    } bank_regs_t;

endpackage

/* File: burst_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module burst_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             sys_clk,   // System clock
    input  wire logic             srst,      // Synchronous reset
    input  wire logic             in_valid,  // Entry offered
    output logic                  in_ready,  // Room for an entry
    input  wire logic [WIDTH-1:0] in_data,   // Entry
    output logic                  out_valid, // Head entry present
    input  wire logic             out_ready, // Sink takes head
    output logic [WIDTH-1:0]      out_data   // Head entry
);

    localparam int unsigned CNT_W = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [CNT_W-1:0]            count;
        logic                        valid;
    } fifo_state_t;

    fifo_state_t s;
    fifo_state_t n;
    logic        pop;
    logic        push;

    // ************************************************************
    // Shift-register queue; the head always sits in entry zero
    // ************************************************************
    assign in_ready  = s.count != CNT_W'(DEPTH);
    assign out_valid = s.valid;
    assign out_data  = s.mem[0];

    always_comb begin
        n    = s;
        pop  = s.valid && out_ready;
        push = in_valid && in_ready;
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                n.mem[i] = s.mem[i+1];
            end
            n.count = s.count - CNT_W'(1);
        end
        if (push) begin
            n.mem[n.count] = in_data;
            n.count        = n.count + CNT_W'(1);
        end
        n.valid = n.count != '0;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

endmodule

`default_nettype wire

/* File: cmd_source.sv */
`timescale 1ns/1ps
`default_nettype none
`include "burst_cmd_defines.svh"

// ****************************************************************
// Memory controller model: drives the command pins
// ****************************************************************
module cmd_source (
    input  wire logic                 sys_clk, // System clock
    output var  burst_cmd_pkg::pins_t pins     // Command pins
);
    logic flip;

    initial begin
        pins = '1;
        flip = 1'b0;
    end

    // One command for one cycle; write data stays on dq until the next
    task automatic send(input logic [3:0] code, input logic bank,
                        input logic [`ADDR_W-1:0] addr,
                        input logic [`DATA_W-1:0] data);
        @(posedge sys_clk);
        #2;
        {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = code;
        pins.bank_sel = bank;
        pins.addr = addr;
        pins.dq = data;
    endtask

    // Deselect and no-operation in turn, don't-care pins scrambled
    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            #2;
            flip = ~flip;
            {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = {flip, 3'h7};
            pins.bank_sel = 1'($urandom);
            pins.addr = 11'($urandom);
        end
    endtask
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "burst_cmd_defines.svh"

module tb;
    localparam int unsigned BL    = 4;
    localparam logic [3:0]  OPEN  = 4'h3;
    localparam logic [3:0]  RD    = 4'h5;
    localparam logic [3:0]  WR    = 4'h4;
    localparam logic [3:0]  CLOSE = 4'h2;
    localparam logic [3:0]  STOP  = 4'h6;
    localparam logic        BANK  = 1'b1;

    logic                        sys_clk, srst, array_ready, stall;
    logic                        array_valid, autoclose_done;
    burst_cmd_pkg::pins_t        pins;
    burst_cmd_pkg::array_req_t   array_req, e, got;
    burst_cmd_pkg::bank_state_t  bank_state;
    logic [`ADDR_W-1:0]          open_row, row;
    logic [`DATA_W-1:0]          wd;
    logic [`COL_W-1:0]           c;
    burst_cmd_pkg::array_req_t   exp_q[$];
    int                          errors, num_checks, seen_rec, seen_done, d;

    cmd_source cmd_source_inst (.sys_clk(sys_clk), .pins(pins));

    burst_cmd_bank #(.BURST_LEN(BL), .FIFO_DEPTH(8), .BANK_ID(BANK))
    burst_cmd_bank_inst (
        .sys_clk(sys_clk), .srst(srst), .pins(pins),
        .array_ready(array_ready), .array_valid(array_valid),
        .array_req(array_req), .bank_state(bank_state),
        .open_row(open_row), .autoclose_done(autoclose_done)
    );

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic check(input string what, input logic [63:0] x,
                         input logic [63:0] y);
        num_checks++;
        if (y !== x) begin
            errors++;
            $display("unexpected %s: expected %0h, seen %0h", what, x, y);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic beats(input logic st, input logic [7:0] col, input int n);
        burst_cmd_pkg::array_req_t q;
        for (int i = 0; i < n; i++) begin
            q.is_store = st;
            q.row = row;
            q.col = col + 8'(i);
            q.data = st ? wd : '0;
            exp_q.push_back(q);
        end
    endtask

    task automatic colc(input logic [3:0] code, input logic ac);
        c = 8'($urandom);
        wd = 16'($urandom);
        cmd_source_inst.send(code, BANK, {ac, 2'($urandom), c}, wd);
    endtask

    task automatic open_row_cmd;
        row = 11'($urandom);
        cmd_source_inst.send(OPEN, BANK, row, 16'($urandom));
        cmd_source_inst.quiet(2);
    endtask

    task automatic settle;
        int n;
        n = 0;
        cmd_source_inst.quiet(10);
        while ((exp_q.size() != 0 || array_valid !== 1'b0) && n < 300) begin
            cmd_source_inst.quiet(1);
            n++;
        end
        check("pending requests", 0, exp_q.size());
    endtask

    // ************************************************************
    // Far side of the array port and result monitor
    // ************************************************************
    always @(posedge sys_clk) begin
        #2;
        array_ready = !stall && ($urandom % 4 != 0);
    end

    always @(posedge sys_clk) begin
        if (!srst) begin
            if (bank_state === burst_cmd_pkg::st_write_recovery) seen_rec++;
            if (autoclose_done === 1'b1) seen_done++;
            if (array_valid === 1'b1 && array_ready === 1'b1) begin
                e = exp_q.size() != 0 ? exp_q.pop_front() : '1;
                got = array_req;
                if (!e.is_store) got.data = '0;
                check("array request", e, got);
            end
        end
    end

    initial begin
        #(25 * 20000);
        errors++;
        complete_run();
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        void'($urandom(58907));
        {errors, num_checks, seen_rec, seen_done} = '0;
        srst = 1'b1;
        stall = 1'b0;
        array_ready = 1'b0;
        row = '0;
        wd = '0;
        repeat (6) @(posedge sys_clk);
        #2 srst = 1'b0;
        check("reset state", {3'h0, 1'b0, 11'h000}, {bank_state, array_valid, open_row});
        open_row_cmd();
        colc(RD, 1'b0); beats(0, c, BL);
        cmd_source_inst.send(RD, ~BANK, 11'($urandom), wd);
        settle();
        check("state", burst_cmd_pkg::st_row_active, bank_state);
        for (int k = 0; k < 6; k++) begin
            d = 1 + $urandom % 3;
            colc(RD, 1'b0); beats(0, c, d - 1); cmd_source_inst.quiet(d - 1);
            cmd_source_inst.send(STOP, 1'($urandom), 11'($urandom), wd);
            settle();
            check("state", burst_cmd_pkg::st_row_active, bank_state);
            check("open row", row, open_row);
            colc(RD, 1'b0); beats(0, c, d - 1); cmd_source_inst.quiet(d - 1);
            colc(RD, 1'b0); beats(0, c, BL); settle();
            check("state", burst_cmd_pkg::st_row_active, bank_state);
            colc(WR, 1'b0); beats(1, c, d - 1); cmd_source_inst.quiet(d - 1);
            colc(WR, 1'b0); beats(1, c, d - 1); cmd_source_inst.quiet(d - 1);
            colc(RD, 1'b0); beats(0, c, BL); settle();
            check("state", burst_cmd_pkg::st_row_active, bank_state);
            colc(WR, 1'b0); beats(1, c, d - 1); cmd_source_inst.quiet(d - 1);
            cmd_source_inst.send(STOP, 1'($urandom), 11'($urandom), wd);
            settle();
            check("state", burst_cmd_pkg::st_row_active, bank_state);
            seen_rec = 0;
            colc(WR, 1'b0); beats(1, c, BL); settle();
            check("write recovery seen", 1, seen_rec != 0);
            check("state", burst_cmd_pkg::st_row_active, bank_state);
            colc(RD, 1'b0); beats(0, c, d - 1); cmd_source_inst.quiet(d - 1);
            cmd_source_inst.send(CLOSE, BANK, {k[0], 10'($urandom)}, wd);
            settle();
            check("state", burst_cmd_pkg::st_idle, bank_state);
            open_row_cmd();
            colc(WR, 1'b0); beats(1, c, d - 1); cmd_source_inst.quiet(d - 1);
            cmd_source_inst.send(CLOSE, BANK, {~k[0], 10'($urandom)}, wd);
            settle();
            check("state", burst_cmd_pkg::st_idle, bank_state);
            open_row_cmd();
            seen_done = 0;
            colc(RD, 1'b1); beats(0, c, BL); settle();
            check("state", burst_cmd_pkg::st_idle, bank_state);
            check("autoclose pulses", 1, seen_done);
            open_row_cmd();
            colc(WR, 1'b1); beats(1, c, BL); settle();
            check("state", burst_cmd_pkg::st_idle, bank_state);
            open_row_cmd();
        end
        stall = 1'b1;
        cmd_source_inst.quiet(2);
        repeat (3) begin
            colc(RD, 1'b0); beats(0, c, BL); cmd_source_inst.quiet(5);
        end
        check("full buffer valid", 1, array_valid);
        check("stalled burst state", burst_cmd_pkg::st_reading, bank_state);
        stall = 1'b0;
        settle();
        check("state", burst_cmd_pkg::st_row_active, bank_state);
        complete_run();
    end
endmodule
`default_nettype wire
